// File: hdl/flash_timing_and_autoread.sv
// Flash timing reloads, program/erase sequencer and auto-read word copies.
`timescale 1ns/1ps
module flash_timing_and_autoread
#(
  parameter int ERASE_SCALE = flash_timing_pkg::ERASE_SCALE_DEF
)
(
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_n,
  // CPU register port.
  input wire flash_timing_pkg::reg_req_t i_reg,
  output logic [flash_timing_pkg::WORD_W-1:0] o_reg_rdata,
  // Operation requests from the flash controller.
  input wire flash_timing_pkg::op_req_t i_op,
  output logic o_op_ready,
  // Flash array control.
  output flash_timing_pkg::array_ctrl_t o_array,
  // Information block words from the array.
  input wire logic [flash_timing_pkg::WORD_W-1:0] i_info_function_word,
  input wire logic [flash_timing_pkg::WORD_W-1:0] i_info_protection_word,
  // Transceiver power control inputs.
  input wire logic i_usb_ctrl_active,
  input wire logic i_module_configuration_usb_en,
  // Auto-read results.
  output logic o_words_valid,
  output logic [flash_timing_pkg::WORD_W-1:0] o_code_area_start,
  output logic o_xcvr_low_power
);
  import flash_timing_pkg::*;

  top_state_t s_r;
  top_state_t s_nxt;
  logic tick;
  logic step_done;
  logic [WORD_W-1:0] code_start_bits;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Down-counter load value for a delay of scale times reload plus one ticks.
  function automatic logic [COUNT_W-1:0] load_value(input logic [RELOAD_W-1:0] rl,
                                                   input int scale);
    int unsigned full;
    full = (int'(rl) + 1) * scale - 1;
    return full[COUNT_W-1:0];
  endfunction

  // Read data for a register index; unmapped indices read zero.
  function automatic logic [WORD_W-1:0] read_mux(input top_state_t st,
                                                 input logic [ADDR_W-1:0] a,
                                                 input logic [WORD_W-1:0] code);
    logic [WORD_W-1:0] d;
    d = '0;
    if (a <= IDX_RCV)
    begin
      d = {{(WORD_W-RELOAD_W){1'b0}}, st.reload[a[2:0]]};
    end
    else if (a == IDX_DIV)
    begin
      d = {{(WORD_W-DIV_W){1'b0}}, st.divisor};
    end
    else if (a == IDX_FUNC || a == IDX_ALIAS_FUNC)
    begin
      d = st.func_word;
    end
    else if (a == IDX_PROT || a == IDX_ALIAS_PROT)
    begin
      d = st.prot_word;
    end
    else if (a == IDX_CODE || a == IDX_ALIAS_CODE)
    begin
      d = code;
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Prescaler, restarted while idle so each operation starts on a fresh phase.
  flash_prescaler u_prescaler
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_divisor(s_r.divisor),
    .i_restart(s_r.state == ST_IDLE),
    .o_tick(tick)
  );

  // The code area start is built from the captured boot field.
  always_comb
  begin
    code_start_bits = '0;
    code_start_bits[CODE_BITS_HI:CODE_BITS_LO] =
      ~s_r.prot_word[PROT_BOOT_HI:PROT_BOOT_LO];
  end

  assign step_done = tick && s_r.count == '0;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic: capture, register writes, reads and sequencer.
  always_comb
  begin
    s_nxt = s_r;
    // Words are taken once, on the first clock after reset release.
    if (!s_r.captured)
    begin
      s_nxt.captured = 1'b1;
      s_nxt.func_word = i_info_function_word;
      s_nxt.prot_word = i_info_protection_word;
    end
    // Writable registers; read-only copies and aliases ignore writes.
    if (i_reg.wr)
    begin
      if (i_reg.addr <= IDX_RCV)
      begin
        s_nxt.reload[i_reg.addr[2:0]] = i_reg.wdata[RELOAD_W-1:0];
      end
      else if (i_reg.addr == IDX_DIV)
      begin
        s_nxt.divisor = i_reg.wdata[DIV_W-1:0];
      end
    end
    if (i_reg.rd)
    begin
      s_nxt.rdata = read_mux(s_r, i_reg.addr, code_start_bits);
    end
    // Sequencer: each phase counts down on prescaler ticks.
    case (s_r.state)
      ST_IDLE:
      begin
        if (i_op.valid)
        begin
          s_nxt.kind = i_op.kind;
          s_nxt.state = ST_START;
          s_nxt.count = load_value(s_r.reload[IDX_START[2:0]], UNIT_SCALE);
        end
      end
      ST_START:
      begin
        if (step_done)
        begin
          s_nxt.state = ST_TRAN;
          s_nxt.count = load_value(s_r.reload[IDX_TRAN[2:0]], UNIT_SCALE);
        end
        else if (tick)
        begin
          s_nxt.count = s_r.count - 1'b1;
        end
      end
      ST_TRAN:
      begin
        if (step_done)
        begin
          s_nxt.state = ST_PULSE;
          if (s_r.kind == OP_PROGRAM)
          begin
            s_nxt.count = load_value(s_r.reload[IDX_PROG[2:0]], PROG_SCALE);
          end
          else if (s_r.kind == OP_PAGE_ERASE)
          begin
            s_nxt.count = load_value(s_r.reload[IDX_PAGE[2:0]], ERASE_SCALE);
          end
          else
          begin
            s_nxt.count = load_value(s_r.reload[IDX_MODULE[2:0]], ERASE_SCALE);
          end
        end
        else if (tick)
        begin
          s_nxt.count = s_r.count - 1'b1;
        end
      end
      ST_PULSE:
      begin
        if (step_done && s_r.kind == OP_MODULE_ERASE)
        begin
          s_nxt.state = ST_MEND;
          s_nxt.count = load_value(s_r.reload[IDX_MEND[2:0]], MEND_SCALE);
        end
        else if (step_done)
        begin
          s_nxt.state = ST_END;
          s_nxt.count = load_value(s_r.reload[IDX_END[2:0]], UNIT_SCALE);
        end
        else if (tick)
        begin
          s_nxt.count = s_r.count - 1'b1;
        end
      end
      ST_END, ST_MEND:
      begin
        if (step_done)
        begin
          s_nxt.state = ST_RECOVER;
          s_nxt.count = load_value(s_r.reload[IDX_RCV[2:0]], UNIT_SCALE);
        end
        else if (tick)
        begin
          s_nxt.count = s_r.count - 1'b1;
        end
      end
      ST_RECOVER:
      begin
        if (step_done)
        begin
          s_nxt.state = ST_IDLE;
          s_nxt.count = '0;
        end
        else if (tick)
        begin
          s_nxt.count = s_r.count - 1'b1;
        end
      end
      default:
      begin
        s_nxt.state = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; reset leaves the sequencer idle and loads the reload and divisor defaults.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_r <= '0;
      s_r.state <= ST_IDLE;
      s_r.kind <= OP_PROGRAM;
      s_r.reload <= RELOAD_RESET;
      s_r.divisor <= DIV_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign o_reg_rdata = s_r.rdata;
  assign o_op_ready = s_r.state == ST_IDLE;
  assign o_array.busy = s_r.state != ST_IDLE;
  assign o_array.prog_pulse = s_r.state == ST_PULSE && s_r.kind == OP_PROGRAM;
  assign o_array.erase_pulse = s_r.state == ST_PULSE && s_r.kind != OP_PROGRAM;
  assign o_array.module_erase = s_r.kind == OP_MODULE_ERASE && s_r.state != ST_IDLE;
  assign o_words_valid = s_r.captured;
  assign o_code_area_start = code_start_bits;
  // Low power is forced by the word, else follows controller and configuration.
  assign o_xcvr_low_power = !s_r.func_word[FUNC_XCVR_EN_BIT]
    || !(i_usb_ctrl_active && i_module_configuration_usb_en);

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  logic [WORD_W-1:0] func_seen;
  logic [COUNT_W-1:0] count_seen;
  assign func_seen = s_r.func_word;
  assign count_seen = s_r.count;

  sequence op_taken;
    s_r.state == ST_IDLE && i_op.valid;
  endsequence

  sequence phase_ends(seq_state_t st);
    s_r.state == st && step_done;
  endsequence

  a_start_load: assert property (op_taken |=> s_r.state == ST_START
    && count_seen == COUNT_W'(s_r.reload[IDX_START[2:0]]))
    else $error("start delay not loaded");

  a_tran_load: assert property (phase_ends(ST_START) |=> s_r.state == ST_TRAN
    && count_seen == COUNT_W'(s_r.reload[IDX_TRAN[2:0]]))
    else $error("transition delay not loaded");

  a_prog_pulse_len: assert property (phase_ends(ST_TRAN) && s_r.kind == OP_PROGRAM
    |=> o_array.prog_pulse && count_seen == load_value(s_r.reload[IDX_PROG[2:0]], PROG_SCALE))
    else $error("program pulse length wrong");

  a_page_pulse_len: assert property (phase_ends(ST_TRAN) && s_r.kind == OP_PAGE_ERASE
    |=> o_array.erase_pulse
      && count_seen == load_value(s_r.reload[IDX_PAGE[2:0]], ERASE_SCALE))
    else $error("page erase pulse length wrong");

  a_module_pulse_len: assert property (phase_ends(ST_TRAN) && s_r.kind == OP_MODULE_ERASE
    |=> o_array.erase_pulse
      && count_seen == load_value(s_r.reload[IDX_MODULE[2:0]], ERASE_SCALE))
    else $error("module erase pulse length wrong");

  a_end_delay: assert property (phase_ends(ST_PULSE) && s_r.kind != OP_MODULE_ERASE
    |=> s_r.state == ST_END && count_seen == COUNT_W'(s_r.reload[IDX_END[2:0]]))
    else $error("end delay not loaded");

  a_mend_delay: assert property (phase_ends(ST_PULSE) && s_r.kind == OP_MODULE_ERASE
    |=> s_r.state == ST_MEND
      && count_seen == load_value(s_r.reload[IDX_MEND[2:0]], MEND_SCALE))
    else $error("module erase end delay not loaded");

  a_recovery_then_idle: assert property (phase_ends(ST_RECOVER)
    |=> !o_array.busy && o_op_ready)
    else $error("busy held after recovery");

  a_busy_through_op: assert property (op_taken |=> o_array.busy [*2])
    else $error("busy dropped early");

  a_code_area_bits: assert property (o_words_valid |->
    o_code_area_start[CODE_ZERO_HI:0] == '0 && !o_code_area_start[CODE_HIGH_BIT]
    && o_code_area_start[CODE_BITS_HI:CODE_BITS_LO]
      == ~s_r.prot_word[PROT_BOOT_HI:PROT_BOOT_LO])
    else $error("code area start malformed");

  a_alias_equal: assert property (i_reg.rd && i_reg.addr == IDX_ALIAS_FUNC
    |=> o_reg_rdata == func_seen)
    else $error("alias read differs from copy");

  a_ro_write_held: assert property (o_words_valid && i_reg.wr && i_reg.addr == IDX_FUNC
    |=> $stable(func_seen))
    else $error("read-only copy changed by write");

  a_xcvr_forced: assert property (o_words_valid && !func_seen[FUNC_XCVR_EN_BIT]
    |-> o_xcvr_low_power)
    else $error("transceiver not forced to low power");

endmodule // flash_timing_and_autoread

// File: include/flash_timing_pkg.sv
// Constants, field layouts and state types of the flash timing and auto-read block.
package flash_timing_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Widths.
  localparam int RELOAD_W = 8;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 4;
  localparam int DIV_W = 5;
  localparam int COUNT_W = 20;
  localparam int NUM_RELOAD = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices on the CPU register port.
  localparam logic [ADDR_W-1:0] IDX_START = 4'h0;
  localparam logic [ADDR_W-1:0] IDX_TRAN = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_PROG = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_PAGE = 4'h3;
  localparam logic [ADDR_W-1:0] IDX_MODULE = 4'h4;
  localparam logic [ADDR_W-1:0] IDX_END = 4'h5;
  localparam logic [ADDR_W-1:0] IDX_MEND = 4'h6;
  localparam logic [ADDR_W-1:0] IDX_RCV = 4'h7;
  localparam logic [ADDR_W-1:0] IDX_DIV = 4'h8;
  localparam logic [ADDR_W-1:0] IDX_FUNC = 4'h9;
  localparam logic [ADDR_W-1:0] IDX_PROT = 4'hA;
  localparam logic [ADDR_W-1:0] IDX_CODE = 4'hB;
  localparam logic [ADDR_W-1:0] IDX_ALIAS_FUNC = 4'hC;
  localparam logic [ADDR_W-1:0] IDX_ALIAS_PROT = 4'hD;
  localparam logic [ADDR_W-1:0] IDX_ALIAS_CODE = 4'hE;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, reload index 7 down to 0.
  localparam logic [NUM_RELOAD-1:0][RELOAD_W-1:0] RELOAD_RESET =
    {8'h04, 8'h3C, 8'h18, 8'hEA, 8'h04, 8'h16, 8'h30, 8'h18};
  localparam logic [DIV_W-1:0] DIV_RESET = 5'h04;

  ////////////////////////////////////////////////////////////////////////////////
  // Delay scale factors; the erase scale feeds a top-level parameter.
  localparam int PROG_SCALE = 8;
  localparam int MEND_SCALE = 8;
  localparam int ERASE_SCALE_DEF = 4096;
  localparam int UNIT_SCALE = 1;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions of the captured words and of the code area start.
  localparam int FUNC_XCVR_EN_BIT = 0;
  localparam int PROT_WRITE_HI = 15;
  localparam int PROT_WRITE_LO = 13;
  localparam int PROT_READ_HI = 12;
  localparam int PROT_READ_LO = 10;
  localparam int PROT_ISP_HI = 9;
  localparam int PROT_ISP_LO = 7;
  localparam int PROT_EMPTY_HI = 6;
  localparam int PROT_EMPTY_LO = 4;
  localparam int PROT_BOOT_HI = 3;
  localparam int PROT_BOOT_LO = 0;
  localparam int CODE_HIGH_BIT = 15;
  localparam int CODE_BITS_HI = 14;
  localparam int CODE_BITS_LO = 11;
  localparam int CODE_ZERO_HI = 10;

  ////////////////////////////////////////////////////////////////////////////////
  // Operation kinds and sequencer states.
  typedef enum logic [1:0] {OP_PROGRAM, OP_PAGE_ERASE, OP_MODULE_ERASE} op_kind_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_TRAN, ST_PULSE, ST_END, ST_MEND, ST_RECOVER
  } seq_state_t;

  // Operation request from the flash controller.
  typedef struct packed {
    logic valid;
    op_kind_t kind;
  } op_req_t;

  // CPU register access.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } reg_req_t;

  // Drive lines to the flash array.
  typedef struct packed {
    logic busy;
    logic prog_pulse;
    logic erase_pulse;
    logic module_erase;
  } array_ctrl_t;

  // Whole state of the top module.
  typedef struct packed {
    seq_state_t state;
    op_kind_t kind;
    logic [COUNT_W-1:0] count;
    logic [NUM_RELOAD-1:0][RELOAD_W-1:0] reload;
    logic [DIV_W-1:0] divisor;
    logic captured;
    logic [WORD_W-1:0] func_word;
    logic [WORD_W-1:0] prot_word;
    logic [WORD_W-1:0] rdata;
  } top_state_t;

  // Whole state of the prescaler.
  typedef struct packed {
    logic [DIV_W-1:0] count;
    logic tick;
  } presc_state_t;

endpackage

// File: hdl/flash_prescaler.sv
// Prescaler that turns the system clock into one-cycle prescaler output ticks.
`timescale 1ns/1ps
module flash_prescaler
(
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Divisor and restart.
  input wire logic [flash_timing_pkg::DIV_W-1:0] i_divisor,
  input wire logic i_restart,
  // Tick out.
  output logic o_tick
);
  import flash_timing_pkg::*;

  presc_state_t s_r;
  presc_state_t s_nxt;

  // One tick every divisor plus one clocks; restart realigns the phase.
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (i_restart || s_r.count == '0)
    begin
      s_nxt.count = i_divisor;
      s_nxt.tick = !i_restart && s_r.count == '0;
    end
    else
    begin
      s_nxt.count = s_r.count - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign o_tick = s_r.tick;

  // Ticks are spaced by exactly divisor plus one clocks when the divisor is steady.
  a_tick_spacing: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    s_r.count == i_divisor && !i_restart && $stable(i_divisor)
      |-> ##1 (s_r.count == i_divisor - 1'b1 || i_divisor == '0))
    else $error("prescaler count did not step down");

endmodule // flash_prescaler

// File: test/flash_array_model.sv
// Flash array stand-in: serves information words and times the drive pulses.
`timescale 1ns/1ps
module flash_array_model
(
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Words to serve and array drive lines.
  input wire logic [15:0] i_func,
  input wire logic [15:0] i_prot,
  input wire flash_timing_pkg::array_ctrl_t i_array,
  // Served words and measured pulse lengths.
  output logic [15:0] o_func_word,
  output logic [15:0] o_prot_word,
  output logic [15:0] o_prog_len,
  output logic [15:0] o_erase_len
);
  import flash_timing_pkg::*;
  logic served_r;
  logic busy_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Words hold only up to the capture edge; later reads of the lines see junk.
  assign o_func_word = served_r ? ~i_func : i_func;
  assign o_prot_word = served_r ? ~i_prot : i_prot;

  // Pulse widths are counted afresh for each operation.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      served_r <= 1'b0;
      busy_r <= 1'b0;
      o_prog_len <= 16'h0;
      o_erase_len <= 16'h0;
    end
    else
    begin
      served_r <= 1'b1;
      busy_r <= i_array.busy;
      if (i_array.busy && !busy_r)
      begin
        o_prog_len <= 16'h0;
        o_erase_len <= 16'h0;
      end
      else
      begin
        o_prog_len <= o_prog_len + 16'(i_array.prog_pulse);
        o_erase_len <= o_erase_len + 16'(i_array.erase_pulse);
      end
    end
  end
endmodule // flash_array_model

// File: test/flash_timing_and_autoread_tb.sv
// Self-checking bench of the flash timing and auto-read block.
`timescale 1ns/1ps
module flash_timing_and_autoread_tb;
  import flash_timing_pkg::*;
  localparam int ESC = 4;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  reg_req_t rq = '0;
  op_req_t op = '0;
  logic usb_act = 1'b0;
  logic cfg_en = 1'b0;
  logic [15:0] func_v = 16'h0;
  logic [15:0] prot_v = 16'h0;
  logic [15:0] rdata, code, fw, pw, plen, elen, g;
  logic ready, wvalid, lowpwr;
  array_ctrl_t arr;
  logic [7:0] rl [0:8];
  int error_cnt = 0;
  int n_compared = 0;
  int seed = 65;

  flash_timing_and_autoread #(.ERASE_SCALE(ESC)) DUT (.i_clock(clock), .i_rst_n(rst_n),
    .i_reg(rq), .o_reg_rdata(rdata), .i_op(op), .o_op_ready(ready), .o_array(arr),
    .i_info_function_word(fw), .i_info_protection_word(pw), .i_usb_ctrl_active(usb_act),
    .i_module_configuration_usb_en(cfg_en), .o_words_valid(wvalid),
    .o_code_area_start(code), .o_xcvr_low_power(lowpwr));
  flash_array_model u_array (.i_clock(clock), .i_rst_n(rst_n), .i_func(func_v),
    .i_prot(prot_v), .i_array(arr), .o_func_word(fw), .o_prot_word(pw),
    .o_prog_len(plen), .o_erase_len(elen));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog.
  always #2 clock = ~clock;
  initial
  begin
    repeat (40000) @(posedge clock);
    error_cnt++;
    summarize();
  end

  // Compares one result and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Register write and read, one-cycle strobes.
  task automatic wr(input int a, input logic [15:0] d);
    @(posedge clock);
    #1 rq = '{wr: 1'b1, rd: 1'b0, addr: 4'(a), wdata: d};
    @(posedge clock);
    #1 rq.wr = 1'b0;
  endtask
  task automatic rd(input int a, output logic [15:0] d);
    @(posedge clock);
    #1 rq = '{wr: 1'b0, rd: 1'b1, addr: 4'(a), wdata: 16'h0};
    @(posedge clock);
    #1 rq.rd = 1'b0;
    d = rdata;
  endtask

  // Resets the block with new information words.
  task automatic do_reset(input logic [15:0] f, input logic [15:0] p);
    func_v = f;
    prot_v = p;
    rst_n = 1'b0;
    repeat (10) @(posedge clock);
    #1 chk("reset_flags", 4'b0101, {wvalid, ready, arr.busy, lowpwr});
    chk("reset_code_rdata", {16'h7800, 16'h0000}, {code, rdata});
    rst_n = 1'b1;
    @(posedge clock);
    #1;
  endtask

  // Expected code area start.
  function automatic logic [15:0] exp_code(input logic [15:0] p);
    return {1'b0, ~p[3:0], 11'h000};
  endfunction

  // Reload reset values, auto-read copies, aliases and read-only writes.
  task automatic check_after_reset();
    logic [7:0] tab [0:8];
    logic [15:0] ro [0:6];
    tab = '{8'h18, 8'h30, 8'h16, 8'h04, 8'hEA, 8'h18, 8'h3C, 8'h04, 8'h04};
    ro = '{func_v, prot_v, exp_code(prot_v), func_v, prot_v, exp_code(prot_v), 16'h0};
    chk("busy", 1'b0, arr.busy);
    chk("words_valid", 1'b1, wvalid);
    chk("code_port", exp_code(prot_v), code);
    for (int i = 0; i < 9; i++)
    begin
      rd(i, g);
      chk("reload_reset", {8'h00, tab[i]}, g);
    end
    for (int pass = 0; pass < 2; pass++)
    begin
      for (int i = 9; i < 16; i++)
      begin
        rd(i, g);
        chk("autoread", ro[i-9], g);
        if (pass == 0)
          wr(i, 16'hFFFF);
      end
    end
    for (int j = 0; j < 4; j++)
    begin
      @(posedge clock);
      #1 usb_act = j[0];
      cfg_en = j[1];
      #1 chk("low_power", !func_v[0] || !(j[0] && j[1]), lowpwr);
    end
    $display("test reset_and_autoread done");
  endtask

  // Runs one operation, with a refused request in mid-run, and times it.
  task automatic run_op(input int k);
    int n;
    int m;
    int t;
    int d;
    d = rl[8] + 1;
    t = rl[0] + rl[1] + rl[7] + 3;
    t += (k == 0) ? 8 * (rl[2] + 1) : ESC * ((k == 1 ? rl[3] : rl[4]) + 1);
    t += (k == 2) ? 8 * (rl[6] + 1) : rl[5] + 1;
    @(posedge clock);
    #1 op = '{valid: 1'b1, kind: op_kind_t'(k)};
    @(posedge clock);
    // The first pass of the loop below lowers the request in this same step.
    #1;
    n = 0;
    m = 0;
    while (arr.busy === 1'b1 && n < 5000)
    begin
      op = '{valid: n == 3, kind: op_kind_t'((k + 1) % 3)};
      n++;
      m += int'(arr.module_erase);
      @(posedge clock);
      #1;
    end
    op.valid = 1'b0;
    chk("busy_len", 1'b1, n >= t * d && n <= t * d + 2);
    chk("prog_len", k == 0 ? 8 * (rl[2] + 1) * d : 0, plen);
    chk("erase_len", k == 0 ? 0 : ESC * ((k == 1 ? rl[3] : rl[4]) + 1) * d, elen);
    chk("module_flag", k == 2 ? n : 0, m);
    chk("ready", 1'b1, ready);
    $display("test operation %0d done", k);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    do_reset(16'($random(seed)) & 16'hFFFE, 16'($random(seed)));
    check_after_reset();
    for (int i = 0; i < 9; i++)
    begin
      rl[i] = 8'($random(seed));
      wr(i, {8'($random(seed)), rl[i]});
      rd(i, g);
      chk("reload_rw", i < 8 ? {8'h00, rl[i]} : {11'h0, rl[i][4:0]}, g);
    end
    $display("test reload_rw done");
    for (int i = 0; i < 9; i++)
    begin
      rl[i] = 8'($random(seed)) & 8'h03;
      wr(i, {8'h00, rl[i]});
    end
    for (int k = 0; k < 3; k++)
      run_op(k);
    for (int k = 2; k >= 0; k--)
      run_op(k);
    @(posedge clock);
    #1 op = '{valid: 1'b1, kind: OP_MODULE_ERASE};
    @(posedge clock);
    #1 op.valid = 1'b0;
    repeat (5) @(posedge clock);
    #1;
    do_reset(16'($random(seed)) | 16'h0001, 16'($random(seed)));
    check_after_reset();
    summarize();
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
endmodule // flash_timing_and_autoread_tb
